// >>> testbench/port_b_far_side.sv
// far-side model: the eight external pins and the upper address source
// assumes the testbench changes ext_en, ext_val and addr_val after a clock edge
`timescale 1ns/1ps
module port_b_far_side
(
  input  wire logic       pclk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_on,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] addr_val,
  output      logic [7:0] pin_in,
  output      logic [7:0] addr_hi
);
  // floating pins change every cycle so that nothing reads as a clean level
  logic [7:0] float_val = 8'h00;

  // toggling pattern for undriven pins
  always_ff @(posedge pclk)
  begin
    float_val <= ~float_val;
  end

  // the address source is a plain level set by the testbench
  assign addr_hi = addr_val;

  // wire level: block drive wins, then an external driver, then the pull-up
  always_comb
  begin
    pin_in = (pin_oe & pin_out)
           | (~pin_oe & ext_en & ext_val)
           | (~pin_oe & ~ext_en & pullup_on)
           | (~pin_oe & ~ext_en & ~pullup_on & float_val);
  end
endmodule

// >>> testbench/port_b_pin_mux_pullup_tb_top.sv
// self-checking testbench of the port b pin function and pull-up block
// assumes the far-side model in port_b_far_side.sv and the design files
`timescale 1ns/1ps
`include "port_b_defines.svh"
module port_b_pin_mux_pullup_tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [2:0]  op_mode;
  logic        hw_standby;
  logic        manual_reset_n;
  logic [7:0]  addr_hi, pin_in, pin_out, pin_oe, pullup_on;
  logic [7:0]  ext_en, ext_val, addr_val;   // far-side stimulus
  logic [7:0]  dv, ov, pv, e, pe;           // chosen values and expectations
  logic [3:0]  ae;
  logic [2:0]  m;
  logic        h;
  logic [31:0] rd;                          // last apb read data
  logic        err;                         // last apb error flag
  int          n_mismatch;
  int          comparisons;

  port_b_gpio dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .op_mode(op_mode), .hw_standby(hw_standby),
    .manual_reset_n(manual_reset_n), .addr_hi(addr_hi), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on));

  port_b_far_side far (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_on(pullup_on), .ext_en(ext_en), .ext_val(ext_val), .addr_val(addr_val),
    .pin_in(pin_in), .addr_hi(addr_hi));

  // 200 mhz clock
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // one comparison, reported at once on a mismatch
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; the request stands until pready is seen at a rising
  // edge, where read data and error are taken too; only the watchdog ends a wait
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // values read here are those the slave showed as this edge arrived
    while (pready !== 1'b1)
      @(posedge pclk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // read and compare data and error flag
  task rchk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(32'(err), 32'(eerr));
  endtask

  // pins carrying an address: expanded modes only, field above the pin index
  function automatic logic [7:0] en_f(input logic [2:0] md, input logic [3:0] f);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
      r[i] = (md >= `PB_MODE_EXT_LO) && (md <= `PB_MODE_EXT_HI) && (f > i);
    return r;
  endfunction

  // verdict and end of run
  task close_out;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // watchdog, far beyond the expected run of about a thousand cycles
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    close_out;
  end

  // main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    op_mode = 3'h7;
    hw_standby = 1'b0;
    manual_reset_n = 1'b1;
    ext_en = 8'hFF;
    ext_val = 8'h00;
    addr_val = 8'h00;
    n_mismatch = 0;
    comparisons = 0;
    void'($urandom(45));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`PB_OFF_PULLUP, 32'h0, 1'b0);
    rchk(`PB_OFF_DIRECTION, 32'h0, 1'b0);
    rchk(`PB_OFF_FUNC_CTRL, 32'h0, 1'b0);
    rchk(12'h014, 32'h0, 1'b1);
    chk(32'(pin_oe | pullup_on), 32'h0);
    $display("test reset_values done");
    apb(1'b1, `PB_OFF_PULLUP, 32'hFFFF_FFA5);
    rchk(`PB_OFF_PULLUP, 32'hA5, 1'b0);
    apb(1'b1, `PB_OFF_FUNC_CTRL, 32'hFFFF_FFFF);
    rchk(`PB_OFF_FUNC_CTRL, 32'h0F, 1'b0);
    pstrb <= 4'h0;
    apb(1'b1, `PB_OFF_PULLUP, 32'h0);
    pstrb <= 4'hF;
    rchk(`PB_OFF_PULLUP, 32'hA5, 1'b0);
    apb(1'b1, `PB_OFF_DIRECTION, 32'hFF);
    rchk(`PB_OFF_DIRECTION, 32'h0, 1'b0);
    apb(1'b1, `PB_OFF_OUTPUT_DATA, 32'h0000_005A);
    rchk(`PB_OFF_OUTPUT_DATA, 32'h5A, 1'b0);
    // pin level is read-only: the write is dropped without an error
    apb(1'b1, `PB_OFF_PIN_LEVEL, 32'hFF);
    chk(32'(err), 32'h0);
    rchk(`PB_OFF_PIN_LEVEL, 32'h5A, 1'b0);
    $display("test register_access done");
    // every field code in expanded modes first, then random mixes
    for (int i = 0; i < 48; i++)
    begin
      m = (i < 16) ? 3'(4 + i % 3) : 3'($urandom_range(7));
      ae = (i < 16) ? 4'(i) : 4'($urandom_range(15));
      dv = 8'($urandom);
      ov = 8'($urandom);
      pv = 8'($urandom);
      h = ($urandom_range(3) == 0);
      e = en_f(m, ae);
      pe = h ? 8'h00 : (~e & ~dv & pv);
      op_mode <= m;
      hw_standby <= h;
      addr_val <= 8'($urandom);
      ext_val <= 8'($urandom);
      ext_en <= ~pe;
      apb(1'b1, `PB_OFF_DIRECTION, 32'(dv));
      apb(1'b1, `PB_OFF_OUTPUT_DATA, 32'(ov));
      apb(1'b1, `PB_OFF_PULLUP, 32'(pv));
      apb(1'b1, `PB_OFF_FUNC_CTRL, 32'(ae));
      // two sync stages plus the output register, with margin
      repeat (6) @(posedge pclk);
      chk(32'(pin_oe), 32'(e | dv));
      chk(32'(pin_out & pin_oe), 32'(((e & addr_val) | (~e & ov)) & (e | dv)));
      chk(32'(pullup_on), 32'(pe));
      rchk(`PB_OFF_PIN_LEVEL, 32'((dv & ov) | (~dv & e & addr_val) | (~dv & ~e & (pe | ext_val))),
           1'b0);
    end
    $display("test pin_functions done");
    manual_reset_n <= 1'b0;
    repeat (6) @(posedge pclk);
    manual_reset_n <= 1'b1;
    repeat (4) @(posedge pclk);
    rchk(`PB_OFF_PULLUP, 32'h0, 1'b0);
    rchk(`PB_OFF_FUNC_CTRL, 32'h0, 1'b0);
    chk(32'(pin_oe | pullup_on), 32'h0);
    $display("test manual_reset done");
    close_out;
  end
endmodule

// >>> verilog/port_b_defines.svh
// constants of the port b pin-function and pull-up block
// assumes inclusion by bare name from the package and the top module
`ifndef PORT_B_DEFINES_SVH
`define PORT_B_DEFINES_SVH

// register byte offsets on the apb slave
`define PB_OFF_DIRECTION   12'h000
`define PB_OFF_OUTPUT_DATA 12'h004
`define PB_OFF_PIN_LEVEL   12'h008
`define PB_OFF_PULLUP      12'h00C
`define PB_OFF_FUNC_CTRL   12'h010

// reset values
`define PB_DIRECTION_RST   8'h00
`define PB_OUTPUT_DATA_RST 8'h00
`define PB_PULLUP_RST      8'h00
`define PB_AE_RST          4'h0

// field positions inside the function control register
`define PB_AE_LSB          0
`define PB_AE_MSB          3

// operating mode codes: expanded modes 4 to 6, single-chip mode 7
`define PB_MODE_EXT_LO     3'h4
`define PB_MODE_EXT_HI     3'h6
`define PB_MODE_SINGLE     3'h7

`endif

// >>> verilog/port_b_gpio.sv
// port b: pin function selection, output data and input pull-ups
// assumes an apb master on pclk; pins, mode straps, hardware standby and
// manual reset come from outside the clock domain; addr_hi is on pclk
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "port_b_defines.svh"
module port_b_gpio
#(
  parameter int ADDR_W = 12,  // apb address width
  parameter int DATA_W = 32   // apb data width
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output      logic              pready,
  output      logic [DATA_W-1:0] prdata,
  output      logic              pslverr,
  input  wire logic [2:0]        op_mode,
  input  wire logic              hw_standby,
  input  wire logic              manual_reset_n,
  input  wire logic [7:0]        addr_hi,
  input  wire logic [7:0]        pin_in,
  output      logic [7:0]        pin_out,
  output      logic [7:0]        pin_oe,
  output      logic [7:0]        pullup_on
);
  import port_b_pkg::*;

  // the register layout assumes one 32-bit word per register
  if (DATA_W != 32)
  begin
    $error("port_b_gpio: DATA_W must be 32");
  end
  if (ADDR_W < 5 || ADDR_W > 12)
  begin
    $error("port_b_gpio: ADDR_W must be 5 to 12");
  end

  port_b_state_t st;       // registered state
  port_b_state_t next_st;  // next state

  logic [11:0] addr12;     // address widened to the offset width
  logic        setup;      // apb setup cycle
  logic        wr_done;    // write completes this edge
  logic        addr_mode;  // expanded modes 4 to 6

  port_b_pinmux_if pm ();  // carrier to the pin multiplexer

  // pad the bus address up to the width of the offsets
  assign addr12    = 12'(paddr);
  assign setup     = psel && !penable;
  assign wr_done   = psel && penable && st.pready && pwrite;
  // mode is read only after both sync stages
  assign addr_mode = (st.mode_s2 >= `PB_MODE_EXT_LO) &&
                     (st.mode_s2 <= `PB_MODE_EXT_HI);

  // pin level as seen by software
  function automatic logic [7:0] pin_level(input logic [7:0] dir,
                                           input logic [7:0] dout,
                                           input logic [7:0] pins);
    return (dir & dout) | (~dir & pins);
  endfunction

  // feed the multiplexer from registered state, except addr_hi which comes straight from the port
  assign pm.addr_mode  = addr_mode;
  assign pm.hw_standby = st.hwsb_s2;
  assign pm.ae         = st.ae;
  assign pm.dir        = st.dir;
  assign pm.dout       = st.dout;
  assign pm.pu         = st.pu;
  assign pm.addr_hi    = addr_hi;

  // pin function multiplexer
  port_b_pin_mux u_mux
  (
    .pm (pm)
  );

  // next-state logic: synchronisers, bus slave, registers, pin outputs
  always_comb
  begin
    next_st = st;

    // two-stage synchronisers; first stage feeds only the second
    next_st.pin_s1  = pin_in;
    next_st.pin_s2  = st.pin_s1;
    next_st.mode_s1 = op_mode;
    next_st.mode_s2 = st.mode_s1;
    next_st.hwsb_s1 = hw_standby;
    next_st.hwsb_s2 = st.hwsb_s1;
    next_st.mrst_s1 = manual_reset_n;
    next_st.mrst_s2 = st.mrst_s1;

    // zero wait state: ready follows the setup cycle by one edge
    next_st.pready  = setup;
    next_st.pslverr = 1'b0;
    next_st.prdata  = '0;

    // read data and error are prepared in the setup cycle
    if (setup)
    begin
      if (addr12 == `PB_OFF_DIRECTION)
      begin
        next_st.prdata = '0;
      end
      else if (addr12 == `PB_OFF_OUTPUT_DATA)
      begin
        next_st.prdata = {24'h000000, st.dout};
      end
      else if (addr12 == `PB_OFF_PIN_LEVEL)
      begin
        next_st.prdata = {24'h000000, pin_level(st.dir, st.dout, st.pin_s2)};
      end
      else if (addr12 == `PB_OFF_PULLUP)
      begin
        next_st.prdata = {24'h000000, st.pu};
      end
      else if (addr12 == `PB_OFF_FUNC_CTRL)
      begin
        next_st.prdata = {28'h0000000, st.ae};
      end
      else
      begin
        // unmapped: error, data zero
        next_st.pslverr = 1'b1;
      end
    end

    // writes land on the completing edge; only byte lane 0 is stored
    if (wr_done && pstrb[0])
    begin
      if (addr12 == `PB_OFF_DIRECTION)
      begin
        next_st.dir = pwdata[7:0];
      end
      else if (addr12 == `PB_OFF_OUTPUT_DATA)
      begin
        next_st.dout = pwdata[7:0];
      end
      else if (addr12 == `PB_OFF_PULLUP)
      begin
        next_st.pu = pwdata[7:0];
      end
      else if (addr12 == `PB_OFF_FUNC_CTRL)
      begin
        next_st.ae = pwdata[`PB_AE_MSB:`PB_AE_LSB];
      end
      else
      begin
        // pin level and unmapped writes are dropped
        next_st.ae = st.ae;
      end
    end

    // manual reset returns the registers to their reset values;
    // it wins over a write landing in the same cycle
    if (!st.mrst_s2)
    begin
      next_st.dir  = `PB_DIRECTION_RST;
      next_st.dout = `PB_OUTPUT_DATA_RST;
      next_st.pu   = `PB_PULLUP_RST;
      next_st.ae   = `PB_AE_RST;
    end

    // pins are registered so every output leaves a flip-flop;
    // costs one cycle from a register change to the pin
    next_st.pin_out   = pm.pin_out;
    next_st.pin_oe    = pm.pin_oe;
    next_st.pullup_on = pm.pullup_on;
  end

  // state register; power-on reset clears everything except the manual reset stages, which are set to 1
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st         <= '0;
      st.mrst_s1 <= 1'b1;
      st.mrst_s2 <= 1'b1;
      st.dir     <= `PB_DIRECTION_RST;
      st.dout    <= `PB_OUTPUT_DATA_RST;
      st.pu      <= `PB_PULLUP_RST;
      st.ae      <= `PB_AE_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs straight from the state flip-flops
  assign pready    = st.pready;
  assign pslverr   = st.pslverr;
  assign prdata    = st.prdata;
  assign pin_out   = st.pin_out;
  assign pin_oe    = st.pin_oe;
  assign pullup_on = st.pullup_on;

  // checks on the pin multiplexer and the bus slave
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_pin7_addr: assert property
    ((addr_mode && st.ae[3]) |=> (pin_oe[7] && pin_out[7] == $past(addr_hi[7])))
    else $error("pin7 not driving address bit 15");

  a_pin7_port: assert property
    ((addr_mode && !st.ae[3])
      |=> (pin_oe[7] == $past(st.dir[7]) &&
           (!pin_oe[7] || pin_out[7] == $past(st.dout[7]))))
    else $error("pin7 not a port pin");

  a_pin6_addr: assert property
    ((addr_mode && (st.ae == 4'h7 || st.ae[3]))
      |=> (pin_oe[6] && pin_out[6] == $past(addr_hi[6])))
    else $error("pin6 not driving address bit 14");

  a_pin5_addr: assert property
    ((addr_mode && (st.ae[3:1] == 3'h3 || st.ae[3]))
      |=> (pin_oe[5] && pin_out[5] == $past(addr_hi[5])))
    else $error("pin5 not driving address bit 13");

  a_pin4_port: assert property
    ((addr_mode && (st.ae == 4'h4 || st.ae[3:2] == 2'h0))
      |=> (pin_oe[4] == $past(st.dir[4]) &&
           (!pin_oe[4] || pin_out[4] == $past(st.dout[4]))))
    else $error("pin4 not a port pin");

  a_pin4_addr: assert property
    ((addr_mode && !(st.ae == 4'h4 || st.ae[3:2] == 2'h0))
      |=> (pin_oe[4] && pin_out[4] == $past(addr_hi[4])))
    else $error("pin4 not driving address bit 12");

  a_pin3_addr: assert property
    ((addr_mode && st.ae[3:2] != 2'h0)
      |=> (pin_oe[3] && pin_out[3] == $past(addr_hi[3])))
    else $error("pin3 not driving address bit 11");

  a_pin2_port: assert property
    ((addr_mode && (st.ae == 4'h2 || st.ae[3:1] == 3'h0))
      |=> (pin_oe[2] == $past(st.dir[2])))
    else $error("pin2 not a port pin");

  a_pin2_addr: assert property
    ((addr_mode && !(st.ae == 4'h2 || st.ae[3:1] == 3'h0))
      |=> (pin_oe[2] && pin_out[2] == $past(addr_hi[2])))
    else $error("pin2 not driving address bit 10");

  a_pin1_addr: assert property
    ((addr_mode && st.ae[3:1] != 3'h0)
      |=> (pin_oe[1] && pin_out[1] == $past(addr_hi[1])))
    else $error("pin1 not driving address bit 9");

  a_pin0_port: assert property
    ((addr_mode && st.ae == 4'h0)
      |=> (pin_oe[0] == $past(st.dir[0]) && pullup_on[0] ==
           ($past(st.pu[0]) && !$past(st.dir[0]) && !$past(st.hwsb_s2))))
    else $error("pin0 not a port pin");

  a_pin0_addr: assert property
    ((addr_mode && st.ae != 4'h0)
      |=> (pin_oe[0] && pin_out[0] == $past(addr_hi[0])))
    else $error("pin0 not driving address bit 8");

  a_single_chip: assert property
    (!addr_mode |=> (pin_oe == $past(st.dir) && pin_out == $past(st.dout)))
    else $error("single-chip pin not following direction");

  a_standby_off: assert property
    (st.hwsb_s2 |=> (pullup_on == 8'h00))
    else $error("pull-up on in hardware standby");

  a_drive_off: assert property
    ((pullup_on & pin_oe) == 8'h00)
    else $error("pull-up on a driven pin");

  a_pullup_input: assert property
    (!st.hwsb_s2 |=> (pullup_on == ($past(st.pu) & ~pin_oe)))
    else $error("pull-up wrong for input pin");

  a_pin_read: assert property
    ((setup && !pwrite && addr12 == `PB_OFF_PIN_LEVEL)
      |=> (prdata[7:0] == (($past(st.dir) & $past(st.dout)) |
                           (~$past(st.dir) & $past(st.pin_s2)))))
    else $error("pin level read wrong");

  a_dir_reads_zero: assert property
    ((setup && addr12 == `PB_OFF_DIRECTION) |=> (prdata == '0 && !pslverr))
    else $error("direction register not write-only");

  a_pullup_write: assert property
    ((wr_done && pstrb[0] && st.mrst_s2 && addr12 == `PB_OFF_PULLUP)
      |=> (st.pu == $past(pwdata[7:0])))
    else $error("pull-up enable write lost");

  a_ae_write: assert property
    ((wr_done && pstrb[0] && st.mrst_s2 && addr12 == `PB_OFF_FUNC_CTRL)
      |=> (st.ae == $past(pwdata[3:0])))
    else $error("address enable field write lost");

  a_mrst_clear: assert property
    (!st.mrst_s2 |=> (st.pu == 8'h00 && st.dir == 8'h00 && st.ae == 4'h0))
    else $error("manual reset left a register set");

  a_ready_once: assert property
    (setup |=> (pready ##1 !pready))
    else $error("apb ready not a single cycle");

  a_err_ready: assert property
    (pslverr |-> pready)
    else $error("apb error without ready");

  c_addr_full: cover property (addr_mode && st.ae == 4'h8 ##1 pin_oe == 8'hFF);
  c_pullup_in: cover property (!addr_mode && pullup_on != 8'h00);
  c_bad_addr:  cover property (pready && pslverr);
  c_back2back: cover property (pready ##3 pready);
  c_standby:   cover property (st.hwsb_s2 && pullup_on == 8'h00);
endmodule

// >>> verilog/port_b_pin_mux.sv
// combinational pin function multiplexer for the eight port b pins
// assumes the top registers every result before it reaches a pin
`timescale 1ns/1ps
module port_b_pin_mux
(
  port_b_pinmux_if.mux pm
);
  import port_b_pkg::*;

  // which pins carry an address bit for a given enable field
  function automatic logic [7:0] addr_pin_enable(input logic [3:0] ae);
    logic [7:0] en;
    en = 8'h00;
    en[7] = ae[3];
    en[6] = (ae == 4'h7) || ae[3];
    en[5] = (ae[3:1] == 3'h3) || ae[3];
    en[4] = !((ae == 4'h4) || (ae[3:2] == 2'h0));
    en[3] = !(ae[3:2] == 2'h0);
    en[2] = !((ae == 4'h2) || (ae[3:1] == 3'h0));
    en[1] = !(ae[3:1] == 3'h0);
    en[0] = (ae != 4'h0);
    return en;
  endfunction

  // pin drive, enable and pull-up per pin
  always_comb
  begin
    logic [7:0] en;
    en = pm.addr_mode ? addr_pin_enable(pm.ae) : 8'h00;
    // address pins drive, others follow direction bit
    pm.pin_oe  = en | pm.dir;
    pm.pin_out = (en & pm.addr_hi) | (~en & pm.dout);
    pm.pullup_on = pm.hw_standby ? 8'h00 : (~en & ~pm.dir & pm.pu);
  end
endmodule

// >>> verilog/port_b_pinmux_if.sv
// carrier between the port b top and its pin multiplexer
// assumes one clock domain; all signals are combinational here
`timescale 1ns/1ps
interface port_b_pinmux_if;
  logic       addr_mode;   // modes 4 to 6 active
  logic       hw_standby;  // hardware standby level
  logic [3:0] ae;          // addr_out_enable_field
  logic [7:0] dir;         // direction_reg
  logic [7:0] dout;        // output_data_reg
  logic [7:0] pu;          // pullup_enable
  logic [7:0] addr_hi;     // addr_bit_15 .. addr_bit_8
  logic [7:0] pin_oe;      // resulting enables
  logic [7:0] pin_out;     // resulting drive
  logic [7:0] pullup_on;   // resulting pull-ups

  modport ctrl (output addr_mode, hw_standby, ae, dir, dout, pu, addr_hi,
                input  pin_oe, pin_out, pullup_on);
  modport mux  (input  addr_mode, hw_standby, ae, dir, dout, pu, addr_hi,
                output pin_oe, pin_out, pullup_on);
endinterface

// >>> verilog/port_b_pkg.sv
// types shared by the port b top module and its pin multiplexer
// assumes port_b_defines.svh is on the include path
package port_b_pkg;
  `include "port_b_defines.svh"

  // all state of the top module
  typedef struct packed {
    logic [7:0]  pin_s1;     // pin level, first sync stage
    logic [7:0]  pin_s2;     // pin level, second sync stage
    logic [2:0]  mode_s1;    // mode straps, first stage
    logic [2:0]  mode_s2;    // mode straps, second stage
    logic        hwsb_s1;    // hardware standby, first stage
    logic        hwsb_s2;    // hardware standby, second stage
    logic        mrst_s1;    // manual reset (low), first stage
    logic        mrst_s2;    // manual reset (low), second stage
    logic [7:0]  dir;        // direction_reg
    logic [7:0]  dout;       // output_data_reg
    logic [7:0]  pu;         // pullup_enable
    logic [3:0]  ae;         // addr_out_enable_field
    logic        pready;     // apb ready
    logic        pslverr;    // apb error
    logic [31:0] prdata;     // apb read data
    logic [7:0]  pin_out;    // registered pin drive
    logic [7:0]  pin_oe;     // registered pin enable
    logic [7:0]  pullup_on;  // registered pull-up control
  } port_b_state_t;
endpackage
